// file: hw/uart_pins_pkg.sv
package uart_pins_pkg;
	localparam int          NUM_CH        = 2;
	localparam logic [2:0]  ADDR_RBR      = 3'h0;
	localparam logic [2:0]  ADDR_IER      = 3'h1;
	localparam logic [2:0]  ADDR_IIR      = 3'h2;
	localparam logic [2:0]  ADDR_LCR      = 3'h3;
	localparam logic [2:0]  ADDR_MCR      = 3'h4;
	localparam logic [2:0]  ADDR_LSR      = 3'h5;
	localparam logic [2:0]  ADDR_MSR      = 3'h6;
	localparam logic [2:0]  ADDR_SCR      = 3'h7;
	localparam int          MCR_DTR_BIT   = 0;
	localparam int          MCR_RTS_BIT   = 1;
	localparam int          MCR_OUT_BIT   = 3;
	localparam int          MSR_CTS_BIT   = 4;
	localparam int          MSR_DSR_BIT   = 5;
	localparam int          MSR_RI_BIT    = 6;
	localparam int          MSR_CD_BIT    = 7;
	localparam int          MSR_DRI_BIT   = 2;
	localparam int          EFR_RTS_BIT   = 6;
	localparam int          EFR_CTS_BIT   = 7;
	localparam int          IER_RXD_BIT   = 0;
	localparam int          IER_TXE_BIT   = 1;
	localparam int          IER_ERR_BIT   = 2;
	localparam int          IER_MS_BIT    = 3;
	localparam logic [7:0]  REG_RESET     = 8'h00;
endpackage

// file: hw/bus_if.sv
`timescale 1ns/10ps
`default_nettype none
interface bus_if;
	logic       rd_pulse;
	logic       wr_pulse;
	logic [2:0] addr;
	logic [7:0] wdata;
	modport ctl (output rd_pulse, output wr_pulse, output addr, output wdata);
	modport ch  (input rd_pulse, input wr_pulse, input addr, input wdata);
endinterface
`default_nettype wire

// file: hw/serial_channel.sv
`timescale 1ns/10ps
`default_nettype none
module serial_channel (
	input  wire logic clk_i,
	input  wire logic resetn_i,
	bus_if.ch         bus,
	input  wire logic sel_i,
	input  wire logic cts_n_i,
	input  wire logic dsr_n_i,
	input  wire logic ri_n_i,
	input  wire logic cd_n_i,
	input  wire logic rx_err_i,
	input  wire logic rx_avail_i,
	input  wire logic tx_space_i,
	output logic [7:0] rdata_o,
	output logic      dtr_n_o,
	output logic      rts_n_o,
	output logic      user_output_n_o,
	output logic      irq_o,
	output logic      irq_oe_o,
	output logic      tx_allow_o,
	output logic      rts_flow_o,
	output logic [7:0] lcr_o,
	output logic      wr_data_o,
	output logic      rd_data_o
);
	typedef struct packed {
		logic [7:0] interrupt_enable_reg;
		logic [7:0] modem_control_reg;
		logic [7:0] enhanced_feature_reg;
		logic [7:0] lcr;
		logic [7:0] scr;
		logic [3:0] delta;
		logic [3:0] prev;
	} ch_state_t;

	ch_state_t  s_q, s_d;
	logic [3:0] now;
	logic [3:0] chg;
	logic       wr, rd;
	logic [7:0] modem_status_reg;

	assign now = {~cd_n_i, ~ri_n_i, ~dsr_n_i, ~cts_n_i};
	assign wr  = bus.wr_pulse & sel_i;
	assign rd  = bus.rd_pulse & sel_i;
	// ring delta only on trailing edge (pin going back high)
	assign chg = {now[3] ^ s_q.prev[3], s_q.prev[2] & ~now[2],
	              now[1:0] ^ s_q.prev[1:0]};
	assign modem_status_reg = {now, s_q.delta};

	always_comb begin
		s_d = s_q;
		s_d.prev = now;
		if (rd && bus.addr == uart_pins_pkg::ADDR_MSR)
			s_d.delta = 4'h0;
		s_d.delta = s_d.delta | chg; // set wins over clear
		if (wr) begin
			case (bus.addr)
			uart_pins_pkg::ADDR_IER: s_d.interrupt_enable_reg = bus.wdata;
			uart_pins_pkg::ADDR_IIR: s_d.enhanced_feature_reg = bus.wdata;
			uart_pins_pkg::ADDR_LCR: s_d.lcr = bus.wdata;
			uart_pins_pkg::ADDR_MCR: s_d.modem_control_reg = bus.wdata;
			uart_pins_pkg::ADDR_SCR: s_d.scr = bus.wdata;
			default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	always_comb begin
		case (bus.addr)
		uart_pins_pkg::ADDR_IER: rdata_o = s_q.interrupt_enable_reg;
		uart_pins_pkg::ADDR_IIR: rdata_o = s_q.enhanced_feature_reg;
		uart_pins_pkg::ADDR_LCR: rdata_o = s_q.lcr;
		uart_pins_pkg::ADDR_MCR: rdata_o = s_q.modem_control_reg;
		uart_pins_pkg::ADDR_MSR: rdata_o = modem_status_reg;
		uart_pins_pkg::ADDR_SCR: rdata_o = s_q.scr;
		default:                 rdata_o = uart_pins_pkg::REG_RESET;
		endcase
	end

	assign dtr_n_o = ~s_q.modem_control_reg[uart_pins_pkg::MCR_DTR_BIT];
	assign rts_n_o = ~s_q.modem_control_reg[uart_pins_pkg::MCR_RTS_BIT];
	assign user_output_n_o =
		~s_q.modem_control_reg[uart_pins_pkg::MCR_OUT_BIT];
	assign irq_oe_o = s_q.modem_control_reg[uart_pins_pkg::MCR_OUT_BIT];
	assign irq_o = irq_oe_o & (
		(s_q.interrupt_enable_reg[uart_pins_pkg::IER_RXD_BIT] & rx_avail_i) |
		(s_q.interrupt_enable_reg[uart_pins_pkg::IER_TXE_BIT] & tx_space_i) |
		(s_q.interrupt_enable_reg[uart_pins_pkg::IER_ERR_BIT] & rx_err_i) |
		(s_q.interrupt_enable_reg[uart_pins_pkg::IER_MS_BIT] & (|s_q.delta)));
	// cts gates the transmitter only in auto mode
	assign tx_allow_o = ~s_q.enhanced_feature_reg[uart_pins_pkg::EFR_CTS_BIT]
	                    | now[0];
	assign rts_flow_o = s_q.enhanced_feature_reg[uart_pins_pkg::EFR_RTS_BIT];
	assign lcr_o     = s_q.lcr;
	assign wr_data_o = wr && bus.addr == uart_pins_pkg::ADDR_RBR;
	assign rd_data_o = rd && bus.addr == uart_pins_pkg::ADDR_RBR;
endmodule
`default_nettype wire

// file: hw/dual_uart_host_modem_pins.sv
`timescale 1ns/10ps
`default_nettype none
module dual_uart_host_modem_pins (
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	input  wire logic       chip_select_ch_a_n_i,
	input  wire logic       chip_select_ch_b_n_i,
	input  wire logic       read_strobe_n_i,
	input  wire logic       write_strobe_n_i,
	input  wire logic [2:0] addr_i,
	input  wire logic [7:0] data_i,
	output logic      [7:0] data_o,
	output logic            data_oe_o,
	input  wire logic [1:0] cts_n_i,
	input  wire logic [1:0] dsr_n_i,
	input  wire logic [1:0] ring_n_i,
	input  wire logic [1:0] carrier_detect_n_i,
	input  wire logic [1:0] rx_err_i,
	input  wire logic [1:0] rx_avail_i,
	input  wire logic [1:0] tx_space_i,
	output logic      [1:0] dtr_n_o,
	output logic      [1:0] rts_n_o,
	output logic      [1:0] user_output_n_o,
	output logic      [1:0] irq_o,
	output logic      [1:0] irq_oe_o,
	output logic      [1:0] tx_allow_o,
	output logic      [1:0] rts_flow_o,
	output logic      [1:0] serial_enable_o
);
	localparam int N = uart_pins_pkg::NUM_CH;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers, edge detect between the second and third stage
	typedef struct packed {
		logic [1:0]  sel_n1, sel_n2;
		logic        rd_n1, rd_n2, rd_n3;
		logic        wr_n1, wr_n2, wr_n3;
		logic [2:0]  a1, a2;
		logic [7:0]  d1, d2;
		logic [7:0]  m1, m2;
		logic [7:0]  dout;
		logic        doe;
		logic [1:0]  dtr_n, rts_n, op_n, irq, irq_oe, txa, rtsf, ser_en;
	} top_state_t;

	top_state_t s_q, s_d;
	logic [1:0] sel;
	logic [7:0] rdat [N];
	logic [1:0] c_dtr, c_rts, c_op, c_irq, c_oe, c_txa, c_rtsf;

	bus_if bus ();

	assign sel          = ~s_q.sel_n2;
	assign bus.rd_pulse = s_q.rd_n3 & ~s_q.rd_n2;
	assign bus.wr_pulse = ~s_q.wr_n3 & s_q.wr_n2;
	assign bus.addr     = s_q.a2;
	assign bus.wdata    = s_q.d2;

	////////////////////////////////////////////////////////////////////////
	generate
		for (genvar i = 0; i < N; i++) begin : g_ch
			serial_channel u_ch (
				.clk_i           (clk_i),
				.resetn_i        (resetn_i),
				.bus             (bus),
				.sel_i           (sel[i]),
				.cts_n_i         (s_q.m2[4*i+0]),
				.dsr_n_i         (s_q.m2[4*i+1]),
				.ri_n_i          (s_q.m2[4*i+2]),
				.cd_n_i          (s_q.m2[4*i+3]),
				.rx_err_i        (rx_err_i[i]),
				.rx_avail_i      (rx_avail_i[i]),
				.tx_space_i      (tx_space_i[i]),
				.rdata_o         (rdat[i]),
				.dtr_n_o         (c_dtr[i]),
				.rts_n_o         (c_rts[i]),
				.user_output_n_o (c_op[i]),
				.irq_o           (c_irq[i]),
				.irq_oe_o        (c_oe[i]),
				.tx_allow_o      (c_txa[i]),
				.rts_flow_o      (c_rtsf[i]),
				.lcr_o           (),
				.wr_data_o       (),
				.rd_data_o       ()
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d = s_q;
		s_d.sel_n1 = {chip_select_ch_b_n_i, chip_select_ch_a_n_i};
		s_d.sel_n2 = s_q.sel_n1;
		s_d.rd_n1  = read_strobe_n_i;
		s_d.rd_n2  = s_q.rd_n1;
		s_d.rd_n3  = s_q.rd_n2;
		s_d.wr_n1  = write_strobe_n_i;
		s_d.wr_n2  = s_q.wr_n1;
		s_d.wr_n3  = s_q.wr_n2;
		s_d.a1     = addr_i;
		s_d.a2     = s_q.a1;
		s_d.d1     = data_i;
		s_d.d2     = s_q.d1;
		s_d.m1     = {carrier_detect_n_i[1], ring_n_i[1], dsr_n_i[1], cts_n_i[1],
		              carrier_detect_n_i[0], ring_n_i[0], dsr_n_i[0], cts_n_i[0]};
		s_d.m2     = s_q.m1;
		// both selected: channel a wins the read, avoiding contention
		if (bus.rd_pulse && sel[0])
			s_d.dout = rdat[0];
		else if (bus.rd_pulse && sel[1])
			s_d.dout = rdat[1];
		s_d.doe    = ~s_q.rd_n2 & (|sel);
		s_d.dtr_n  = c_dtr;
		s_d.rts_n  = c_rts;
		s_d.op_n   = c_op;
		s_d.irq    = c_irq;
		s_d.irq_oe = c_oe;
		s_d.txa    = c_txa;
		s_d.rtsf   = c_rtsf;
		s_d.ser_en = 2'h3;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_q        <= '0;
			s_q.sel_n1 <= 2'h3;
			s_q.sel_n2 <= 2'h3;
			s_q.rd_n1  <= 1'h1;
			s_q.rd_n2  <= 1'h1;
			s_q.rd_n3  <= 1'h1;
			s_q.wr_n1  <= 1'h1;
			s_q.wr_n2  <= 1'h1;
			s_q.wr_n3  <= 1'h1;
			s_q.m1     <= 8'hFF;
			s_q.m2     <= 8'hFF;
			s_q.dtr_n  <= 2'h3;
			s_q.rts_n  <= 2'h3;
			s_q.op_n   <= 2'h3;
			s_q.txa    <= 2'h3;
		end else begin
			s_q <= s_d;
		end
	end

	assign data_o          = s_q.dout;
	assign data_oe_o       = s_q.doe;
	assign dtr_n_o         = s_q.dtr_n;
	assign rts_n_o         = s_q.rts_n;
	assign user_output_n_o = s_q.op_n;
	assign irq_o           = s_q.irq;
	assign irq_oe_o        = s_q.irq_oe;
	assign tx_allow_o      = s_q.txa;
	assign rts_flow_o      = s_q.rtsf;
	assign serial_enable_o = s_q.ser_en;
endmodule
`default_nettype wire

// file: verification/uart_pins_props.sv
`timescale 1ns/10ps
`default_nettype none
module uart_pins_props (
	input wire logic       clk_i,
	input wire logic       resetn_i,
	input wire logic       chip_select_ch_a_n_i,
	input wire logic       chip_select_ch_b_n_i,
	input wire logic       read_strobe_n_i,
	input wire logic       write_strobe_n_i,
	input wire logic [1:0] cts_n_i,
	input wire logic       data_oe_o,
	input wire logic [1:0] dtr_n_o,
	input wire logic [1:0] rts_n_o,
	input wire logic [1:0] user_output_n_o,
	input wire logic [1:0] irq_o,
	input wire logic [1:0] irq_oe_o,
	input wire logic [1:0] tx_allow_o,
	input wire logic [1:0] serial_enable_o
);
	// cycles since the write strobe pin last rose, saturating
	logic [3:0] since_wr_q;
	logic       wr_prev_q;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			since_wr_q <= 4'hF;
			wr_prev_q  <= 1'b1;
		end else begin
			wr_prev_q <= write_strobe_n_i;
			if (write_strobe_n_i && !wr_prev_q)
				since_wr_q <= 4'h0;
			else if (since_wr_q != 4'hF)
				since_wr_q <= since_wr_q + 4'h1;
		end
	end
	default clocking dc @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	a_reset_state: assert property (disable iff (1'b0)
		!resetn_i |-> {dtr_n_o, rts_n_o, user_output_n_o} == 6'h3F
		&& irq_oe_o == 2'h0 && !data_oe_o && serial_enable_o == 2'h0)
		else $error("outputs not in reset state");
	a_serial_on: assert property (resetn_i [*2] |-> serial_enable_o == 2'h3)
		else $error("serial side not enabled after reset");
	a_oe_on_read: assert property (
		(!read_strobe_n_i && !chip_select_ch_a_n_i) [*5] |-> data_oe_o)
		else $error("bus not driven during selected read");
	a_oe_off_idle: assert property (read_strobe_n_i [*5] |-> !data_oe_o)
		else $error("bus driven without read strobe");
	a_oe_off_desel: assert property (
		(chip_select_ch_a_n_i && chip_select_ch_b_n_i) [*5] |-> !data_oe_o)
		else $error("bus driven while no channel selected");
	a_op_irq_pair: assert property (user_output_n_o == ~irq_oe_o)
		else $error("user output and interrupt enable disagree");
	a_irq_needs_oe: assert property ((irq_o & ~irq_oe_o) == 2'h0)
		else $error("interrupt raised while pin released");
	a_cts_allows: assert property ((!cts_n_i[0]) [*5] |-> tx_allow_o[0])
		else $error("transmit held with clear-to-send active");
	a_ctl_after_wr: assert property (
		$changed({dtr_n_o, rts_n_o, user_output_n_o})
		|-> since_wr_q inside {[4'h2:4'h7]})
		else $error("modem control output moved without a write");
	c_read: cover property (data_oe_o);
	c_irq: cover property ($rose(irq_o[0]));
	c_flow: cover property ($fell(tx_allow_o[0]));
endmodule
`default_nettype wire

// file: verification/host_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] rdata_i,
	input  wire logic       rdata_oe_i,
	output logic      [1:0] cs_n_o,
	output logic            rd_n_o,
	output logic            wr_n_o,
	output logic      [2:0] addr_o,
	output logic      [7:0] wdata_o
);
	initial begin
		cs_n_o = 2'h3;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		addr_o = 3'h0;
		wdata_o = 8'h00;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask
	// select, address and data lead the strobe by 3 clk, trail it by 1
	task automatic xfer(input logic [1:0] sel, input logic wr,
		input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
		cs_n_o = ~sel;
		addr_o = a;
		wdata_o = d;
		cyc(3);
		if (wr)
			wr_n_o = 1'b0;
		else
			rd_n_o = 1'b0;
		cyc(5);
		// undriven bus reads as the board pull-ups, never unknown
		q = rdata_oe_i ? rdata_i : 8'hFF;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		cyc(1);
		cs_n_o = 2'h3;
		addr_o = ~a;
		wdata_o = ~d; // released lines must not keep the last value
		cyc(3);
	endtask
endmodule
`default_nettype wire

// file: verification/tb_dual_uart_host_modem_pins.sv
`timescale 1ns/10ps
`default_nettype none
module tb_dual_uart_host_modem_pins;
	localparam logic [2:0] A_IER = uart_pins_pkg::ADDR_IER;
	localparam logic [2:0] A_MCR = uart_pins_pkg::ADDR_MCR;
	localparam logic [2:0] A_MSR = uart_pins_pkg::ADDR_MSR;
	localparam logic [2:0] A_SCR = uart_pins_pkg::ADDR_SCR;
	logic        clk_i = 1'b0;
	logic        resetn_i;
	logic [1:0]  cs_n, cts, dsr, ring, cd, err, avail, space;
	logic        rd_n, wr_n, doe;
	logic [2:0]  addr;
	logic [7:0]  wdata, rdata, q, v;
	logic [1:0]  dtr, rts, op, irq, ioe, txa, flow, sen;
	logic [7:0]  mcr_e [2];
	logic [7:0]  scr_e [2];
	logic [31:0] rnd;
	int          n_mismatch, n_checks;
	always #12.5 clk_i = ~clk_i;
	dual_uart_host_modem_pins i_dual_uart_host_modem_pins (.clk_i, .resetn_i,
		.chip_select_ch_a_n_i(cs_n[0]), .chip_select_ch_b_n_i(cs_n[1]),
		.read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .addr_i(addr),
		.data_i(wdata), .data_o(rdata), .data_oe_o(doe), .cts_n_i(cts),
		.dsr_n_i(dsr), .ring_n_i(ring), .carrier_detect_n_i(cd),
		.rx_err_i(err), .rx_avail_i(avail), .tx_space_i(space),
		.dtr_n_o(dtr), .rts_n_o(rts), .user_output_n_o(op), .irq_o(irq),
		.irq_oe_o(ioe), .tx_allow_o(txa), .rts_flow_o(flow),
		.serial_enable_o(sen));
	host_bus_model i_host_bus_model (.clk_i, .rdata_i(rdata),
		.rdata_oe_i(doe), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
		.addr_o(addr), .wdata_o(wdata));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// expected {dtr, rts, user output, irq enable}, channel b in high bit
	function automatic logic [7:0] pins(input logic [7:0] a, input logic [7:0] b);
		return {~b[0], ~a[0], ~b[1], ~a[1], ~b[3], ~a[3], b[3], a[3]};
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (n_mismatch == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(input logic [1:0] s, input logic [2:0] a, input logic [7:0] d);
		logic [7:0] x;
		i_host_bus_model.xfer(s, 1'b1, a, d, x);
	endtask
	task automatic rd(input logic c, input logic [2:0] a, output logic [7:0] x);
		i_host_bus_model.xfer({c, ~c}, 1'b0, a, 8'h00, x);
	endtask
	task automatic cyc(input int n);
		i_host_bus_model.cyc(n);
	endtask
	initial begin
		#1ms;
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		{cts, dsr, ring, cd} = 8'hFF;
		{err, avail, space} = 6'h00;
		resetn_i = 1'b1;
		// real falling edge so the async reset fires before the first clock
		#1;
		resetn_i = 1'b0;
		rnd = 32'h17C8;
		mcr_e = '{8'h00, 8'h00};
		scr_e = '{8'h5A, 8'h5A};
		repeat (6) @(posedge clk_i);
		#2;
		resetn_i = 1'b1;
		cyc(3);
		check({dtr, rts, op, ioe}, pins(8'h00, 8'h00));
		check({5'h0, doe, sen}, 8'h03);
		wr(2'h3, A_SCR, 8'h5A);
		for (int i = 0; i < 12; i++) begin
			rnd = lfsr(rnd);
			{cts, dsr, ring, cd} = rnd[15:8];
			v = rnd[7:0] & 8'hEF; // loopback kept off so status follows the pins
			wr(rnd[17:16], A_MCR, v);
			wr(rnd[17:16], A_SCR, ~v);
			for (int c = 0; c < 2; c++) begin
				if (rnd[16 + c]) begin
					mcr_e[c] = v;
					scr_e[c] = ~v;
				end
			end
			check({dtr, rts, op, ioe}, pins(mcr_e[0], mcr_e[1]));
			for (int c = 0; c < 2; c++) begin
				rd(c[0], A_MCR, q);
				check({4'h0, q[3:0]}, {4'h0, mcr_e[c][3:0]});
				rd(c[0], A_SCR, q);
				check(q, scr_e[c]);
				rd(c[0], A_MSR, q);
				check({q[7:4], 4'h0}, {~cd[c], ~ring[c], ~dsr[c], ~cts[c], 4'h0});
			end
		end
		wr(2'h3, A_MCR, 8'h08);
		for (int k = 0; k < 3; k++) begin
			wr(2'h1, A_IER, 8'h01 << k);
			{err[0], space[0], avail[0]} = 3'h1 << k;
			cyc(3);
			check({6'h0, irq}, 8'h01);
			wr(2'h1, A_IER, 8'h00);
			cyc(2);
			check({6'h0, irq}, 8'h00);
		end
		{err, space, avail} = 6'h01;
		wr(2'h1, A_IER, 8'h01);
		wr(2'h1, A_MCR, 8'h00);
		cyc(2);
		check({4'h0, irq, ioe}, 8'h02);
		avail = 2'h0;
		wr(2'h1, A_MCR, 8'h08);
		wr(2'h1, A_IER, 8'h08);
		ring[0] = 1'b0;
		cyc(4);
		rd(1'b0, A_MSR, q);
		ring[0] = 1'b1;
		cyc(5);
		check({6'h0, irq}, 8'h01);
		rd(1'b0, A_MSR, q);
		cyc(2);
		check({q[2], 5'h0, irq}, 8'h80);
		wr(2'h1, 3'h2, 8'hC0); // enhanced features: both auto flow bits
		cts = 2'h3;
		cyc(5);
		check({4'h0, txa, flow}, 8'h09);
		cts = 2'h0;
		cyc(5);
		check({4'h0, txa, flow}, 8'h0D);
		i_host_bus_model.xfer(2'h0, 1'b0, A_SCR, 8'h00, q);
		check(q, 8'hFF);
		resetn_i = 1'b0;
		cyc(1);
		check({dtr, rts, op, ioe}, pins(8'h00, 8'h00));
		check({5'h0, doe, sen}, 8'h00);
		resetn_i = 1'b1;
		cyc(3);
		rd(1'b1, A_MCR, q);
		check({4'h0, q[3:0]}, 8'h00);
		tally_and_finish();
	end
endmodule
bind dual_uart_host_modem_pins uart_pins_props i_uart_pins_props (.clk_i,
	.resetn_i, .chip_select_ch_a_n_i, .chip_select_ch_b_n_i,
	.read_strobe_n_i, .write_strobe_n_i, .cts_n_i, .data_oe_o, .dtr_n_o,
	.rts_n_o, .user_output_n_o, .irq_o, .irq_oe_o, .tx_allow_o,
	.serial_enable_o);
`default_nettype wire
